// file: inc/acms_pkg.sv
// constants for the capacity, block-count and sleep command interpreter
// Operation
// - F9h replaces max address from task file
// - host sets LBA bit, places 28-bit address
// - device-select bit must match this drive
// - capacity command needs ready, preceding F8h
// - sector count bit 0 keeps max across reset (code: hard reset only; a power-on reset reloads the native max)
// - features select password, lock, unlock, freeze
// - abort later non-volatile capacity command after reset
// - host boot sequence: read native, set, restore
// - 37h sets 48-bit max, previous/current bytes
// - C6h sets busy, checks sector count
// - valid block count stored, multiple enabled
// - unsupported block count aborts, disables multiple
// - zero block count disables multiple
// - multiple disabled after power-on
// - E6h/99h: busy, sleep, clear busy, interrupt
// - any new command wakes and executes
// - idle timer of 5 ms enters sleep
package acms_pkg;
	// ====================================================
	// command codes
	localparam logic [7:0] CMD_SET_MAX = 8'hf9;
	localparam logic [7:0] CMD_SET_MAX_EXT = 8'h37;
	localparam logic [7:0] CMD_READ_NATIVE = 8'hf8;
	localparam logic [7:0] CMD_READ_NATIVE_EXT = 8'h27;
	localparam logic [7:0] CMD_SET_MULT = 8'hc6;
	localparam logic [7:0] CMD_SLEEP_A = 8'he6;
	localparam logic [7:0] CMD_SLEEP_B = 8'h99;
	// ====================================================
	// sub-function codes in the feature register
	localparam logic [7:0] FEAT_OBSOLETE = 8'h00;
	localparam logic [7:0] FEAT_SET_PWD = 8'h01;
	localparam logic [7:0] FEAT_LOCK = 8'h02;
	localparam logic [7:0] FEAT_UNLOCK = 8'h03;
	localparam logic [7:0] FEAT_FREEZE = 8'h04;
	// ====================================================
	// field positions
	localparam int DH_LBA_BIT = 6;
	localparam int DH_DEV_BIT = 4;
	localparam int SC_KEEP_BIT = 0;
	// ====================================================
	// status bits
	localparam int ST_BSY = 7;
	localparam int ST_DRDY = 6;
	localparam int ST_ERR = 0;
	localparam logic [7:0] ERR_ABORT = 8'h04;
	// ====================================================
	// timing
	localparam int CLK_HZ = 20_000_000;
	localparam int IDLE_MS = 5;
	localparam int IDLE_CYC = CLK_HZ / 1000 * IDLE_MS;
	localparam int MAX_BLOCK = 16;
	localparam logic [47:0] NATIVE_MAX_RST = 48'h0000_00ff_ffff;
endpackage : acms_pkg

// file: inc/acms_if.sv
// task-file carrier between host and device ends
`timescale 1ns/1ns
interface acms_if;
	logic [7:0] cmd; // command code
	logic cmd_wr; // command write strobe
	logic [7:0] feature; // feature select
	logic [15:0] sec_cnt; // sector count, prev:cur
	logic [15:0] lba_lo; // sector number / lba low
	logic [15:0] lba_mid; // cylinder low / lba mid
	logic [15:0] lba_hi; // cylinder high / lba high
	logic [7:0] dev_head; // drive/head select
	logic [7:0] status; // status byte
	logic [7:0] error; // error byte
	logic intrq; // interrupt pulse
	logic [47:0] native_max; // read-native result
	modport dev (input cmd, cmd_wr, feature, sec_cnt, lba_lo, lba_mid,
		lba_hi, dev_head, output status, error, intrq, native_max);
	modport host (output cmd, cmd_wr, feature, sec_cnt, lba_lo, lba_mid,
		lba_hi, dev_head, input status, error, intrq, native_max);
endinterface : acms_if

// file: hdl/acms_dev.sv
// device end: executes capacity, block-count and sleep commands
`timescale 1ns/1ns
module acms_dev #(
	parameter int IDLE_CYC = acms_pkg::IDLE_CYC,
	parameter logic [0:0] DEV_ID = 1'b0
) (
	input wire logic i_core_clk, // core clock
	input wire logic i_nrst, // async reset, active low
	input wire logic i_power_on, // power-on vs hard reset
	acms_if.dev tf, // task-file carrier
	output logic [47:0] o_max_addr, // current max address
	output logic [47:0] o_nv_max, // non-volatile max
	output logic [7:0] o_mult_count, // block count
	output logic o_mult_en, // multiple enabled
	output logic o_sleep, // in sleep mode
	output logic [2:0] o_lock_state // {frozen,locked,pwd}
);
	typedef enum logic [1:0] {ACMS_IDLE, ACMS_EXEC, ACMS_DONE} acms_st_t;
	acms_st_t st_q, st_d;
	logic [7:0] cmd_q;
	logic [47:0] max_q, nv_q;
	logic [7:0] mult_q;
	logic mult_en_q, sleep_q, after_f8_q, nv_done_q;
	logic pwd_q, lock_q, frz_q, err_q, irq_q, boot_q;
	logic [31:0] idle_q;
	logic [47:0] addr28, addr48;
	logic sel, is_cap, is_sleep, keep, cap_ok, mult_ok;
	// derived command fields
	logic set_path, nv_wr;
	logic [47:0] new_max;
	// ====================================================
	// decode
	assign sel = (tf.dev_head[acms_pkg::DH_DEV_BIT] == DEV_ID);
	assign addr28 = {20'h00000, tf.dev_head[3:0], tf.lba_hi[7:0],
		tf.lba_mid[7:0], tf.lba_lo[7:0]};
	assign addr48 = {tf.lba_hi[15:8], tf.lba_mid[15:8], tf.lba_lo[15:8],
		tf.lba_hi[7:0], tf.lba_mid[7:0], tf.lba_lo[7:0]};
	assign is_cap = (cmd_q == acms_pkg::CMD_SET_MAX)
		|| (cmd_q == acms_pkg::CMD_SET_MAX_EXT);
	assign is_sleep = (cmd_q == acms_pkg::CMD_SLEEP_A)
		|| (cmd_q == acms_pkg::CMD_SLEEP_B);
	assign keep = tf.sec_cnt[acms_pkg::SC_KEEP_BIT];
	// prerequisites: follows read-native, not locked, nv once per boot
	assign cap_ok = after_f8_q && !lock_q && !(keep && nv_done_q);
	// block count must be a power of two up to the limit
	assign mult_ok = (tf.sec_cnt[7:0] <= 8'(acms_pkg::MAX_BLOCK))
		&& ((tf.sec_cnt[7:0] & (tf.sec_cnt[7:0] - 8'h01)) == 8'h00);
	// feature 00h, or the 48-bit form, is a plain max-address write
	assign set_path = (cmd_q == acms_pkg::CMD_SET_MAX_EXT)
		|| (tf.feature == acms_pkg::FEAT_OBSOLETE);
	// 28-bit layout for the short form, 48-bit layout otherwise
	assign new_max = (cmd_q == acms_pkg::CMD_SET_MAX) ? addr28
		: addr48;
	// a retained set also updates the non-volatile copy
	assign nv_wr = (st_q == ACMS_EXEC) && is_cap && set_path && cap_ok
		&& keep;
	// ====================================================
	// sequencer
	always_comb begin
		st_d = st_q;
		case (st_q)
			ACMS_IDLE: begin
				if (tf.cmd_wr && sel) begin
					st_d = ACMS_EXEC;
				end
			end
			ACMS_EXEC: st_d = ACMS_DONE;
			ACMS_DONE: st_d = ACMS_IDLE;
			default: st_d = ACMS_IDLE;
		endcase
	end
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st_q <= ACMS_IDLE;
			cmd_q <= 8'h00;
		end else begin
			st_q <= st_d;
			if (st_q == ACMS_IDLE && tf.cmd_wr && sel) begin
				cmd_q <= tf.cmd;
			end
		end
	end
	// ====================================================
	// reset-time restore of max from non-volatile copy
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			boot_q <= 1'b1;
		end else begin
			boot_q <= 1'b0;
		end
	end
	// ====================================================
	// non-volatile copy of the max address
	// no async reset here: a hard reset must leave the copy intact,
	// only a power-on reset reloads the native maximum
	// the power-on reset must span at least one clock edge
	always_ff @(posedge i_core_clk) begin
		if (!i_nrst && i_power_on) begin
			nv_q <= acms_pkg::NATIVE_MAX_RST;
		end else if (nv_wr) begin
			nv_q <= new_max;
		end
	end
	// ====================================================
	// command execution
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			max_q <= acms_pkg::NATIVE_MAX_RST;
			mult_q <= 8'h00;
			mult_en_q <= 1'b0;
			after_f8_q <= 1'b0;
			nv_done_q <= 1'b0;
			pwd_q <= 1'b0;
			lock_q <= 1'b0;
			frz_q <= 1'b0;
			err_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			irq_q <= 1'b0;
			if (boot_q) begin
				max_q <= nv_q;
			end
			if (st_q == ACMS_EXEC) begin
				err_q <= 1'b0;
				after_f8_q <= (cmd_q == acms_pkg::CMD_READ_NATIVE)
					|| (cmd_q == acms_pkg::CMD_READ_NATIVE_EXT);
				if (is_cap) begin
					if (set_path) begin
						// out of order, locked or second retained set: abort
						if (!cap_ok) begin
							err_q <= 1'b1;
						end else begin
							max_q <= new_max;
							if (keep) begin
								nv_done_q <= 1'b1;
							end
						end
					end else begin
						// sub-functions of the capacity command
						case (tf.feature)
							acms_pkg::FEAT_SET_PWD: begin
								if (frz_q || lock_q) err_q <= 1'b1;
								else pwd_q <= 1'b1;
							end
							acms_pkg::FEAT_LOCK: begin
								if (frz_q) err_q <= 1'b1;
								else lock_q <= 1'b1;
							end
							acms_pkg::FEAT_UNLOCK: begin
								if (frz_q) err_q <= 1'b1;
								else lock_q <= 1'b0;
							end
							acms_pkg::FEAT_FREEZE: frz_q <= 1'b1;
							default: err_q <= 1'b1;
						endcase
					end
				end else if (cmd_q == acms_pkg::CMD_SET_MULT) begin
					if (tf.sec_cnt[7:0] == 8'h00) begin
						mult_en_q <= 1'b0;
					end else if (mult_ok) begin
						mult_q <= tf.sec_cnt[7:0];
						mult_en_q <= 1'b1;
					end else begin
						err_q <= 1'b1;
						mult_en_q <= 1'b0;
					end
				end
			end
			if (st_q == ACMS_DONE) begin
				irq_q <= 1'b1;
			end
		end
	end
	// ====================================================
	// sleep entry by command or idle timer
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			sleep_q <= 1'b0;
			idle_q <= 32'h0;
		end else if (st_q != ACMS_IDLE || tf.cmd_wr) begin
			// any strobe or command in flight restarts the idle count
			idle_q <= 32'h0;
			if (st_q == ACMS_EXEC) begin
				sleep_q <= is_sleep;
			end else if (tf.cmd_wr && sel) begin
				sleep_q <= 1'b0;
			end
			// count holds at the limit, sleep stays until woken
		end else if (idle_q >= 32'(IDLE_CYC - 1)) begin
			sleep_q <= 1'b1;
		end else begin
			idle_q <= idle_q + 32'h1;
		end
	end
	// ====================================================
	// outputs
	// busy whenever a command is in flight, ready otherwise
	assign tf.status = {st_q != ACMS_IDLE, st_q == ACMS_IDLE, 5'h00, err_q};
	assign tf.error = err_q ? acms_pkg::ERR_ABORT : 8'h00;
	assign tf.intrq = irq_q;
	assign tf.native_max = acms_pkg::NATIVE_MAX_RST;
	assign o_max_addr = max_q;
	assign o_nv_max = nv_q;
	assign o_mult_count = mult_q;
	assign o_mult_en = mult_en_q;
	assign o_sleep = sleep_q;
	assign o_lock_state = {frz_q, lock_q, pwd_q};
endmodule : acms_dev

// file: hdl/acms_host.sv
// host end: loads task file and issues one command per request
`timescale 1ns/1ns
module acms_host (
	input wire logic i_core_clk, // core clock
	input wire logic i_nrst, // async reset, active low
	input wire logic i_req, // issue command pulse
	input wire logic [7:0] i_cmd, // command code
	input wire logic [7:0] i_feature, // feature select
	input wire logic [15:0] i_sec_cnt, // sector count
	input wire logic [47:0] i_addr, // max address
	input wire logic i_lba48, // 48-bit layout
	input wire logic i_dev, // device select
	acms_if.host tf, // task-file carrier
	output logic o_busy, // command in progress
	output logic o_done, // completion pulse
	output logic o_err // last command aborted
);
	logic [7:0] cmd_q, feat_q, dh_q;
	logic [15:0] sc_q, lo_q, mid_q, hi_q;
	logic wr_q, pend_q, done_q, err_q;
	// ====================================================
	// task-file load, lba bit set, 28 or 48-bit layout
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cmd_q <= 8'h00;
			feat_q <= 8'h00;
			dh_q <= 8'h00;
			sc_q <= 16'h0000;
			lo_q <= 16'h0000;
			mid_q <= 16'h0000;
			hi_q <= 16'h0000;
			wr_q <= 1'b0;
			pend_q <= 1'b0;
			done_q <= 1'b0;
			err_q <= 1'b0;
		end else begin
			wr_q <= 1'b0;
			done_q <= 1'b0;
			if (i_req && !pend_q && tf.status[acms_pkg::ST_DRDY]) begin
				cmd_q <= i_cmd;
				feat_q <= i_feature;
				sc_q <= i_sec_cnt;
				dh_q <= {1'b1, 1'b1, 1'b1, i_dev,
					i_lba48 ? 4'h0 : i_addr[27:24]};
				lo_q <= {i_lba48 ? i_addr[31:24] : 8'h00, i_addr[7:0]};
				mid_q <= {i_lba48 ? i_addr[39:32] : 8'h00, i_addr[15:8]};
				hi_q <= {i_lba48 ? i_addr[47:40] : 8'h00, i_addr[23:16]};
				wr_q <= 1'b1;
				pend_q <= 1'b1;
			end else if (pend_q && tf.intrq) begin
				pend_q <= 1'b0;
				done_q <= 1'b1;
				err_q <= tf.status[acms_pkg::ST_ERR];
			end
		end
	end
	assign tf.cmd = cmd_q;
	assign tf.cmd_wr = wr_q;
	assign tf.feature = feat_q;
	assign tf.sec_cnt = sc_q;
	assign tf.lba_lo = lo_q;
	assign tf.lba_mid = mid_q;
	assign tf.lba_hi = hi_q;
	assign tf.dev_head = dh_q;
	assign o_busy = pend_q;
	assign o_done = done_q;
	assign o_err = err_q;
endmodule : acms_host

// file: verification/acms_chk.sv
// assertions on the task-file carrier between host and device
`timescale 1ns/1ns
module acms_chk (
	input wire logic i_core_clk, // core clock
	input wire logic i_nrst, // async reset, active low
	input wire logic [7:0] cmd, // command code
	input wire logic cmd_wr, // command strobe
	input wire logic [7:0] feature, // feature select
	input wire logic [15:0] sec_cnt, // sector count
	input wire logic [7:0] dev_head, // drive/head select
	input wire logic [7:0] status, // status byte
	input wire logic intrq // interrupt pulse
);
	// ====================================================
	// decode of the strobe and status
	logic [7:0] prev_q;
	logic [7:0] prev_d;
	wire logic sel = cmd_wr && !dev_head[acms_pkg::DH_DEV_BIT];
	wire logic [7:0] sc = sec_cnt[7:0];
	wire logic bsy = status[acms_pkg::ST_BSY];
	wire logic err = status[acms_pkg::ST_ERR];
	wire logic oth = cmd_wr && dev_head[acms_pkg::DH_DEV_BIT];
	wire logic c6 = sel && cmd == acms_pkg::CMD_SET_MULT;
	wire logic f9 = sel && cmd == acms_pkg::CMD_SET_MAX;
	wire logic slp = sel && (cmd == acms_pkg::CMD_SLEEP_A
		|| cmd == acms_pkg::CMD_SLEEP_B);
	wire logic nat = prev_q == acms_pkg::CMD_READ_NATIVE;
	// last command taken by this drive
	assign prev_d = sel ? cmd : prev_q;
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) prev_q <= 8'h00;
		else prev_q <= prev_d;
	end
	// ====================================================
	// properties
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);
	a_sleep_seq: assert property (slp
		|=> bsy ##2 (intrq && !bsy)) else $error("sleep sequence wrong");
	a_mult_busy: assert property (c6 |=> bsy)
		else $error("block count without busy");
	a_wrong_dev: assert property (oth |=> !intrq [*4])
		else $error("other drive answered");
	a_mult_abort: assert property (c6 && ($countones(sc) > 1 || sc > 8'h10)
		|-> ##3 intrq && err) else $error("bad count not aborted");
	a_mult_zero: assert property (c6 && sc == 8'h00 |-> ##3 intrq && !err)
		else $error("zero count aborted");
	a_mult_valid: assert property (c6 && $countones(sc) == 1 && sc <= 8'h10
		|-> ##3 intrq && !err) else $error("valid count aborted");
	a_no_native: assert property (f9 && !nat |-> ##3 intrq && err)
		else $error("set max without native read");
	a_rsvd_feat: assert property (f9 && nat && feature > 8'h04
		|-> ##3 intrq && err) else $error("reserved feature taken");
endmodule : acms_chk

// file: verification/acms_tb_top.sv
// table-driven bench for host and device ends
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; \
	$display("[ERR] %0t got %h want %h", $time, a, b); end end
module acms_tb_top;
	typedef struct packed {logic [7:0] p, c, f, s; logic [23:0] a; logic e, z;
		logic [7:0] n; logic [23:0] x;} acms_row_t;
	logic i_core_clk = 1'b0, i_nrst = 1'b0, i_power_on = 1'b1, i_req = 1'b0;
	logic [7:0] i_cmd = 8'h00, i_feature = 8'h00;
	logic [15:0] i_sec_cnt = 16'h0000;
	logic [47:0] i_addr = 48'h0, o_max_addr, o_nv_max;
	logic i_lba48 = 1'b0, i_dev = 1'b0, o_busy, o_done, o_err, o_mult_en, o_sleep;
	logic [7:0] o_mult_count;
	logic [2:0] o_lock_state;
	logic ok;
	int n_errors = 0, comparisons = 0;
	acms_row_t rows [16];
	acms_row_t t;
	acms_if bus ();
	acms_dev #(.IDLE_CYC(40)) acms_dev_inst (.i_core_clk(i_core_clk),
		.i_nrst(i_nrst), .i_power_on(i_power_on), .tf(bus),
		.o_max_addr(o_max_addr), .o_nv_max(o_nv_max),
		.o_mult_count(o_mult_count), .o_mult_en(o_mult_en),
		.o_sleep(o_sleep), .o_lock_state(o_lock_state));
	acms_host acms_host_inst (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
		.i_req(i_req), .i_cmd(i_cmd), .i_feature(i_feature),
		.i_sec_cnt(i_sec_cnt), .i_addr(i_addr), .i_lba48(i_lba48),
		.i_dev(i_dev), .tf(bus), .o_busy(o_busy), .o_done(o_done),
		.o_err(o_err));
	acms_chk acms_chk_inst (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
		.cmd(bus.cmd), .cmd_wr(bus.cmd_wr), .feature(bus.feature),
		.sec_cnt(bus.sec_cnt), .dev_head(bus.dev_head),
		.status(bus.status), .intrq(bus.intrq));
	// ====================================================
	// clock, helpers
	always #25 i_core_clk = ~i_core_clk;
	function automatic acms_row_t r(input logic [7:0] p, c, f, s,
		input logic [23:0] a, input logic e, z, input logic [7:0] n,
		input logic [23:0] x);
		return {p, c, f, s, a, e, z, n, x};
	endfunction : r
	// one command, waits for completion under a bound
	task automatic issue(input logic [7:0] c, f, s, input logic [23:0] a,
		input logic d);
		int k;
		k = 0;
		@(negedge i_core_clk);
		i_cmd = c;
		i_feature = f;
		i_sec_cnt = {8'h00, s};
		i_addr = {24'h0, a};
		i_lba48 = (c == 8'h37);
		i_dev = d;
		i_req = 1'b1;
		@(negedge i_core_clk);
		i_req = 1'b0;
		while (o_done !== 1'b1 && k < 20) begin
			@(negedge i_core_clk);
			k++;
		end
		ok = (o_done === 1'b1);
	endtask : issue
	// read-native then capacity command, back to back
	task automatic set_max(input logic [7:0] f, s, input logic [23:0] a);
		issue(8'hf8, 8'h00, 8'h00, 24'h0, 1'b0);
		issue(8'hf9, f, s, a, 1'b0);
	endtask : set_max
	task automatic reset_dut();
		i_nrst = 1'b0;
		repeat (2) @(negedge i_core_clk);
		i_nrst = 1'b1;
		repeat (2) @(negedge i_core_clk);
	endtask : reset_dut
	task automatic complete_run();
		$display("checks %0d errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : complete_run
	// ====================================================
	// watchdog
	initial begin
		repeat (3000) @(posedge i_core_clk);
		n_errors++;
		$display("[ERR] %0t watchdog expired", $time);
		complete_run();
	end
	// ====================================================
	// main sequence
	initial begin
		rows = '{r(0, 8'hf8, 0, 0, 0, 0, 0, 0, 24'hffffff),
			r(8'hf8, 8'hf9, 0, 0, 24'h123456, 0, 0, 0, 24'h123456),
			r(0, 8'hf9, 0, 0, 24'habcdef, 1, 0, 0, 24'h123456),
			r(8'h27, 8'h37, 0, 0, 24'habcdef, 0, 0, 0, 24'habcdef),
			r(0, 8'hc6, 0, 8'h08, 0, 0, 0, 8'h08, 24'habcdef),
			r(0, 8'hc6, 0, 8'h03, 0, 1, 0, 0, 24'habcdef),
			r(0, 8'hc6, 0, 8'h10, 0, 0, 0, 8'h10, 24'habcdef),
			r(0, 8'hc6, 0, 0, 0, 0, 0, 0, 24'habcdef),
			r(8'hf8, 8'hf9, 8'h05, 0, 24'habcdef, 1, 0, 0, 24'habcdef),
			r(8'hf8, 8'hf9, 8'h01, 0, 24'habcdef, 0, 0, 0, 24'habcdef),
			r(8'hf8, 8'hf9, 0, 8'h01, 24'h654321, 0, 0, 0, 24'h654321),
			r(8'hf8, 8'hf9, 0, 8'h01, 24'h111111, 1, 0, 0, 24'h654321),
			r(8'hf8, 8'hf9, 0, 0, 24'h222222, 0, 0, 0, 24'h222222),
			r(0, 8'he6, 0, 0, 0, 0, 1, 0, 24'h222222),
			r(0, 8'h99, 0, 0, 0, 0, 1, 0, 24'h222222),
			r(0, 8'hc6, 0, 8'h02, 0, 0, 0, 8'h02, 24'h222222)};
		reset_dut();
		`CHK(o_mult_en, 1'b0)
		for (int i = 0; i < 16; i++) begin
			t = rows[i];
			if (t.p !== 8'h00) issue(t.p, 8'h00, 8'h00, 24'h0, 1'b0);
			issue(t.c, t.f, t.s, t.a, 1'b0);
			`CHK(ok, 1'b1)
			`CHK(o_err, t.e)
			`CHK(o_max_addr, {24'h0, t.x})
			`CHK(o_sleep, t.z)
			`CHK(o_mult_en, t.n != 8'h00)
			if (t.n != 8'h00) `CHK(o_mult_count, t.n)
			$display("row %0d done", i);
		end
		`CHK(o_nv_max, 48'h654321)
		`CHK(o_lock_state, 3'b001)
		repeat (60) @(negedge i_core_clk);
		`CHK(o_sleep, 1'b1)
		issue(8'hc6, 8'h00, 8'h04, 24'h0, 1'b1);
		`CHK(ok, 1'b0)
		`CHK(o_mult_count, 8'h02)
		`CHK(o_busy, 1'b1)
		$display("idle and select tests done");
		i_power_on = 1'b0;
		reset_dut();
		`CHK(o_max_addr, 48'h654321)
		`CHK(o_mult_en, 1'b0)
		set_max(8'h00, 8'h00, 24'hffffff);
		`CHK(o_max_addr, 48'hffffff)
		set_max(8'h00, 8'h01, 24'h333333);
		`CHK(o_err, 1'b0)
		`CHK(o_max_addr, 48'h333333)
		`CHK(o_nv_max, 48'h333333)
		$display("hard reset test done");
		set_max(8'h02, 8'h00, 24'h0);
		`CHK(o_lock_state, 3'b010)
		set_max(8'h00, 8'h00, 24'h444444);
		`CHK(o_err, 1'b1)
		`CHK(o_max_addr, 48'h333333)
		set_max(8'h03, 8'h00, 24'h0);
		set_max(8'h04, 8'h00, 24'h0);
		`CHK(o_lock_state, 3'b100)
		set_max(8'h02, 8'h00, 24'h0);
		`CHK(o_err, 1'b1)
		`CHK(o_lock_state, 3'b100)
		$display("lock tests done");
		complete_run();
	end
endmodule : acms_tb_top
